// *** hw/fap_top.sv ***
module fap_top #(
    parameter int N_SECT = fap_pkg::FAP_N_SECT
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [fap_pkg::FAP_ADDR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [fap_pkg::FAP_DATA_W-1:0] wb_dat_w,
    output logic [fap_pkg::FAP_DATA_W-1:0] wb_dat_r,
    output logic wb_ack,
    input wire fap_pkg::fap_src_e fetch_src,
    input wire fap_pkg::fap_nv_s nv_fuses,
    output fap_pkg::fap_prog_s nv_prog,
    input wire fap_pkg::fap_acc_s acc_req,
    output fap_pkg::fap_verdict_s acc_verdict,
    output logic [15:0] trap_vector,
    output logic [15:0] dummy_data,
    input wire logic pe_valid,
    input wire logic [N_SECT-1:0] pe_sectors,
    output logic pe_done,
    output logic pe_blocked,
    output logic [N_SECT-1:0] pe_permit,
    output logic access_protected,
    output logic debug_protected
);
    import fap_pkg::*;

    // *****************************************
    // Reset release
    // *****************************************
    logic rst_q1;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // *****************************************
    // Helper functions
    // *****************************************
    function automatic logic cancel_active(input logic [15:0] dis, input logic [15:0] reen);
        logic hit;
        hit = 1'b0;
        for (int x = 0; x < FAP_N_PAIRS; x++) begin
            if (!dis[x] && reen[x]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    function automatic logic [15:0] disable_ok(input logic [15:0] acc, input logic [15:0] reen);
        logic [15:0] ok;
        ok = '0;
        ok[0] = !acc[FAP_ACCESS_PROTECT_FUSE_BIT] && !acc[FAP_DEBUG_PROTECT_FUSE_BIT];
        for (int x = 1; x < FAP_N_PAIRS; x++) begin
            ok[x] = !reen[x-1];
        end
        return ok;
    endfunction

    function automatic logic [15:0] lane_data(input logic [31:0] d, input logic [3:0] sel);
        return {sel[1] ? d[15:8] : 8'hff, sel[0] ? d[7:0] : 8'hff};
    endfunction

    function automatic logic hit_idx(input logic [FAP_ADDR_W-1:0] a, input logic [21:0] idx);
        return a == {idx, 2'b00};
    endfunction

    // *****************************************
    // Fuse load at reset
    // *****************************************
    fap_load_e load_state;
    logic loaded;
    logic [15:0] fuse_acc;
    logic [15:0] fuse_dis;
    logic [15:0] fuse_reen;
    logic [N_SECT-1:0] fuse_wp;
    logic [N_SECT-1:0] wp_vol;
    logic temp_unprotect_bit;
    logic reject;

    assign loaded = load_state == FAP_LD_DONE;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_state <= FAP_LD_ACCESS;
        end else begin
            case (load_state)
                FAP_LD_ACCESS: load_state <= FAP_LD_DISABLE;
                FAP_LD_DISABLE: load_state <= FAP_LD_REENABLE;
                FAP_LD_REENABLE: load_state <= FAP_LD_SECTOR;
                FAP_LD_SECTOR: load_state <= FAP_LD_DONE;
                default: load_state <= FAP_LD_DONE;
            endcase
        end
    end

    // *****************************************
    // Protection state
    // *****************************************
    logic cancelled;
    logic acc_prot;
    logic dbg_prot;
    logic src_flash;

    assign src_flash = fetch_src == FAP_SRC_FLASH;
    assign cancelled = cancel_active(fuse_dis, fuse_reen);
    // Until the fuses are in, every protection is held on
    assign acc_prot = !loaded || (!fuse_acc[FAP_ACCESS_PROTECT_FUSE_BIT] && !cancelled && !temp_unprotect_bit);
    assign dbg_prot = !loaded || (!fuse_acc[FAP_DEBUG_PROTECT_FUSE_BIT] && !cancelled);

    // *****************************************
    // Wishbone slave
    // *****************************************
    logic req;
    logic wr_now;
    logic hit_acc;
    logic hit_dis;
    logic hit_reen;
    logic hit_wp;
    logic hit_temp_unprotect_bit;
    logic hit_stat;
    logic [15:0] wd;
    logic set_allowed;
    logic set_op;
    logic [31:0] next_rd;

    assign req = wb_cyc && wb_stb;
    assign wr_now = req && wb_ack && wb_we;
    assign hit_acc = hit_idx(wb_adr, FAP_IDX_ACCESS_FUSES);
    assign hit_dis = hit_idx(wb_adr, FAP_IDX_DISABLE);
    assign hit_reen = hit_idx(wb_adr, FAP_IDX_REENABLE);
    assign hit_wp = hit_idx(wb_adr, FAP_IDX_SECTOR_WP);
    assign hit_temp_unprotect_bit = hit_idx(wb_adr, FAP_IDX_TEMP_UNPROT);
    assign hit_stat = hit_idx(wb_adr, FAP_IDX_STATUS);
    assign wd = lane_data(wb_dat_w, wb_sel);
    assign set_op = wr_now && (hit_acc || hit_dis || hit_reen || hit_wp);
    // Protection-set runs only from outside flash and with protection lifted
    assign set_allowed = loaded && !acc_prot && !src_flash;

    always_comb begin
        next_rd = '0;
        if (hit_acc) begin
            next_rd[15:0] = fuse_acc;
        end else if (hit_dis) begin
            next_rd[15:0] = fuse_dis;
        end else if (hit_reen) begin
            next_rd[15:0] = fuse_reen;
        end else if (hit_wp) begin
            next_rd[N_SECT-1:0] = fuse_wp;
        end else if (hit_temp_unprotect_bit) begin
            next_rd[FAP_TEMP_UNPROTECT_BIT_BIT] = temp_unprotect_bit;
        end else if (hit_stat) begin
            next_rd[FAP_ST_LOADED] = loaded;
            next_rd[FAP_ST_ACC_PROT] = acc_prot;
            next_rd[FAP_ST_DBG_PROT] = dbg_prot;
            next_rd[FAP_ST_REJECT] = reject;
            next_rd[FAP_ST_CANCELLED] = cancelled;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack <= 1'b0;
            wb_dat_r <= '0;
        end else begin
            wb_ack <= req && !wb_ack;
            if (req && !wb_ack && !wb_we) begin
                wb_dat_r <= next_rd;
            end
        end
    end

    // *****************************************
    // Temporary unprotect bit
    // *****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            temp_unprotect_bit <= 1'b0;
        end else if (wr_now && hit_temp_unprotect_bit && wb_sel[0]) begin
            if (!wb_dat_w[FAP_TEMP_UNPROTECT_BIT_BIT]) begin
                temp_unprotect_bit <= 1'b0;
            end else if (src_flash) begin
                temp_unprotect_bit <= 1'b1;
            end
        end
    end

    // *****************************************
    // Protection-set on the fuses
    // *****************************************
    logic [15:0] dis_req;
    logic [15:0] dis_grant;
    logic [15:0] reen_req;
    logic [15:0] reen_grant;
    logic [15:0] dis_allow;
    logic bad_bits;

    assign dis_allow = disable_ok(fuse_acc, fuse_reen);
    assign dis_req = fuse_dis & ~wd;
    assign dis_grant = dis_req & dis_allow;
    assign reen_req = fuse_reen & ~wd;
    assign reen_grant = reen_req & ~fuse_dis;
    assign bad_bits = (hit_dis && (dis_req & ~dis_allow) != '0) || (hit_reen && (reen_req & fuse_dis) != '0);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fuse_acc <= FAP_FUSE_ERASED;
            fuse_dis <= FAP_FUSE_ERASED;
            fuse_reen <= FAP_FUSE_ERASED;
        end else if (load_state == FAP_LD_ACCESS) begin
            fuse_acc <= nv_fuses.access;
        end else if (load_state == FAP_LD_DISABLE) begin
            fuse_dis <= nv_fuses.disable_f;
        end else if (load_state == FAP_LD_REENABLE) begin
            fuse_reen <= nv_fuses.reenable;
        end else if (set_op && set_allowed) begin
            if (hit_acc) begin
                fuse_acc <= fuse_acc & wd;
            end
            if (hit_dis) begin
                fuse_dis <= fuse_dis & ~dis_grant;
            end
            if (hit_reen) begin
                fuse_reen <= fuse_reen & ~reen_grant;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fuse_wp <= '0;
            wp_vol <= '0;
        end else if (load_state == FAP_LD_SECTOR) begin
            fuse_wp <= nv_fuses.sector[N_SECT-1:0];
            wp_vol <= nv_fuses.sector[N_SECT-1:0];
        end else if (set_op && set_allowed && hit_wp) begin
            fuse_wp <= fuse_wp & wd[N_SECT-1:0];
            wp_vol <= wd[N_SECT-1:0];
        end
    end

    // Refusal flag; a new refusal wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reject <= 1'b0;
        end else if (set_op && (!set_allowed || bad_bits)) begin
            reject <= 1'b1;
        end else if (wr_now && hit_stat && wb_sel[0] && wb_dat_w[FAP_ST_REJECT]) begin
            reject <= 1'b0;
        end
    end

    // Programming pulse toward the nonvolatile array
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_prog <= '0;
        end else begin
            nv_prog.valid <= set_op && set_allowed;
            if (set_op && set_allowed) begin
                if (hit_acc) begin
                    nv_prog.target <= FAP_F_ACCESS;
                    nv_prog.data <= wd;
                end else if (hit_dis) begin
                    nv_prog.target <= FAP_F_DISABLE;
                    nv_prog.data <= ~dis_grant;
                end else if (hit_reen) begin
                    nv_prog.target <= FAP_F_REENABLE;
                    nv_prog.data <= ~reen_grant;
                end else begin
                    nv_prog.target <= FAP_F_SECTOR;
                    nv_prog.data <= wd;
                end
            end
        end
    end

    // *****************************************
    // Access verdicts
    // *****************************************
    logic next_allow;
    logic next_dummy;

    always_comb begin
        next_allow = 1'b1;
        next_dummy = 1'b0;
        if (acc_req.peripheral_event_transfer) begin
            next_allow = !acc_prot;
        end else if (acc_req.ctrl) begin
            next_allow = !acc_req.write || !acc_prot;
        end else if (!src_flash && acc_prot) begin
            next_allow = 1'b0;
            next_dummy = !acc_req.write;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_verdict <= '0;
        end else begin
            acc_verdict.done <= acc_req.valid;
            acc_verdict.allow <= acc_req.valid && next_allow;
            acc_verdict.dummy <= acc_req.valid && next_dummy;
            acc_verdict.trap <= acc_req.valid && next_dummy;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            trap_vector <= '0;
            dummy_data <= '0;
            access_protected <= 1'b1;
            debug_protected <= 1'b1;
        end else begin
            trap_vector <= FAP_TRAP_VECTOR;
            dummy_data <= FAP_DUMMY_DATA;
            access_protected <= acc_prot;
            debug_protected <= dbg_prot;
        end
    end

    // *****************************************
    // Sector program and erase gating
    // *****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pe_done <= 1'b0;
            pe_blocked <= 1'b0;
            pe_permit <= '0;
        end else begin
            pe_done <= pe_valid;
            pe_blocked <= pe_valid && (!loaded || (pe_sectors & ~wp_vol) != '0);
            pe_permit <= (pe_valid && loaded) ? (pe_sectors & wp_vol) : '0;
        end
    end

    // *****************************************
    // Assertions
    // *****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_load_forces_prot: assert property (!loaded |-> acc_prot && dbg_prot)
        else $error("protection not forced before fuse load");
    a_load_four_steps: assert property ($rose(rst_n) |-> !loaded [*4] ##1 loaded)
        else $error("fuse load did not finish in four cycles");
    a_temp_unprotect_bit_from_flash: assert property ($rose(temp_unprotect_bit) |-> $past(src_flash))
        else $error("unprotect bit set from non-flash code");
    a_temp_unprotect_bit_clear: assert property (wr_now && hit_temp_unprotect_bit && wb_sel[0] && !wb_dat_w[FAP_TEMP_UNPROTECT_BIT_BIT] |=> !temp_unprotect_bit)
        else $error("unprotect bit not cleared");
    a_temp_unprotect_bit_suspends: assert property (loaded && temp_unprotect_bit |-> !acc_prot)
        else $error("unprotect bit did not suspend protection");
    a_cancel_effect: assert property (loaded && cancelled |-> !acc_prot)
        else $error("disable fuse did not cancel protection");
    a_foreign_read: assert property (acc_req.valid && !acc_req.write && !acc_req.peripheral_event_transfer && !acc_req.ctrl
        && !src_flash && acc_prot |=> acc_verdict.dummy && acc_verdict.trap && !acc_verdict.allow)
        else $error("foreign read of protected flash not trapped");
    a_pec_blocked: assert property (acc_req.valid && acc_req.peripheral_event_transfer && acc_prot |=> !acc_verdict.allow)
        else $error("event transfer passed protection");
    a_ctrl_write: assert property (set_op && acc_prot |=> !nv_prog.valid && reject)
        else $error("control write accepted while protected");
    a_dis_order: assert property (loaded && $past(loaded) && $changed(fuse_dis)
        |-> (($past(fuse_dis) & ~fuse_dis) & ~$past(dis_allow)) == '0)
        else $error("disable fuse programmed out of order");
    a_sector_block: assert property (pe_valid && loaded && (pe_sectors & ~wp_vol) != '0 |=> pe_blocked)
        else $error("protected sector not blocked");
    a_ack_pulse: assert property (wb_ack |=> !wb_ack)
        else $error("ack held beyond one cycle");
endmodule

// *** common/fap_pkg.sv ***
// Operation
// - Disable fuse without re-enable cancels access protection
// - First disable fuse needs debug and access protection
// - Disable fuse x needs re-enable fuse x-1 programmed
// - Re-enable fuse restores protection until next disable
// - Re-enable fuse x needs disable fuse x programmed
// - Temporary unprotect bit suspends access protection
// - Only flash-fetched code may set temporary unprotect
// - Protected flash data readable only when fetching flash
// - At most sixteen disable/re-enable cycles, while unprotected
// - Foreign writes ignored, foreign reads give dummy and trap
// - Peripheral event transfers blocked while protected
// - Control register writes rejected while protected
// - Write-protected sectors block program and erase
// - Writing one lifts only volatile sector protection
// - Reset or writing zero reinstates sector protection
// - Fuse register reads show fuses, not volatile copy
// - Reset or clearing unprotect bit reinstates protection
// - Fuses load once at reset, protections forced meanwhile
package fap_pkg;
    localparam int FAP_ADDR_W = 24;
    localparam int FAP_DATA_W = 32;
    localparam int FAP_FUSE_W = 16;
    localparam int FAP_N_PAIRS = 16;
    localparam int FAP_N_SECT = 10;
    // *****************************************
    // Register indices (byte address is four times the index)
    // *****************************************
    localparam logic [21:0] FAP_IDX_ACCESS_FUSES = 22'h08dfb8;
    localparam logic [21:0] FAP_IDX_SECTOR_WP = 22'h08dfb0;
    localparam logic [21:0] FAP_IDX_DISABLE = 22'h08dfbc;
    localparam logic [21:0] FAP_IDX_REENABLE = 22'h08dfbe;
    localparam logic [21:0] FAP_IDX_TEMP_UNPROT = 22'h08dfc0;
    localparam logic [21:0] FAP_IDX_STATUS = 22'h08dfc4;
    // *****************************************
    // Field positions and values
    // *****************************************
    localparam int FAP_ACCESS_PROTECT_FUSE_BIT = 0;
    localparam int FAP_DEBUG_PROTECT_FUSE_BIT = 1;
    localparam int FAP_TEMP_UNPROTECT_BIT_BIT = 0;
    localparam int FAP_ST_LOADED = 0;
    localparam int FAP_ST_ACC_PROT = 1;
    localparam int FAP_ST_DBG_PROT = 2;
    localparam int FAP_ST_REJECT = 3;
    localparam int FAP_ST_CANCELLED = 4;
    localparam logic [15:0] FAP_FUSE_ERASED = 16'hffff;
    localparam logic [15:0] FAP_TRAP_VECTOR = 16'h009b;
    localparam logic [15:0] FAP_DUMMY_DATA = 16'h0000;
    typedef enum logic [1:0] {FAP_SRC_FLASH, FAP_SRC_IRAM, FAP_SRC_XRAM, FAP_SRC_EXT} fap_src_e;
    typedef enum logic [1:0] {FAP_F_ACCESS, FAP_F_DISABLE, FAP_F_REENABLE, FAP_F_SECTOR} fap_fuse_e;
    typedef enum logic [2:0] {FAP_LD_ACCESS, FAP_LD_DISABLE, FAP_LD_REENABLE, FAP_LD_SECTOR, FAP_LD_DONE} fap_load_e;
    typedef struct packed {
        logic [15:0] access;
        logic [15:0] disable_f;
        logic [15:0] reenable;
        logic [15:0] sector;
    } fap_nv_s;
    typedef struct packed {
        logic valid;
        logic write;
        logic peripheral_event_transfer;
        logic ctrl;
    } fap_acc_s;
    typedef struct packed {
        logic done;
        logic allow;
        logic dummy;
        logic trap;
    } fap_verdict_s;
    typedef struct packed {
        logic valid;
        fap_fuse_e target;
        logic [15:0] data;
    } fap_prog_s;
endpackage

// *** bench/fap_fuse_model.sv ***
module fap_fuse_model
    import fap_pkg::*;
(
    input wire logic ref_clk,
    input wire fap_pkg::fap_prog_s nv_prog,
    output fap_pkg::fap_nv_s nv_fuses
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // One-time cells: a programmed 0 never returns to 1
    // ****************************************
    initial nv_fuses = {4{FAP_FUSE_ERASED}};
    always @(posedge ref_clk) begin
        if (nv_prog.valid === 1'b1) begin
            case (nv_prog.target)
                FAP_F_ACCESS: nv_fuses.access <= nv_fuses.access & nv_prog.data;
                FAP_F_DISABLE: nv_fuses.disable_f <= nv_fuses.disable_f & nv_prog.data;
                FAP_F_REENABLE: nv_fuses.reenable <= nv_fuses.reenable & nv_prog.data;
                default: nv_fuses.sector <= nv_fuses.sector & nv_prog.data;
            endcase
        end
    end
endmodule

// *** bench/tb.sv ***
module tb;
    import fap_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [23:0] wb_adr = '0;
    logic [3:0] wb_sel = 4'h3;
    logic [31:0] wb_dat_w = '0;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    fap_src_e fetch_src = FAP_SRC_IRAM;
    fap_nv_s nv_fuses;
    fap_prog_s nv_prog;
    fap_acc_s acc_req = '0;
    fap_verdict_s acc_verdict;
    logic [15:0] trap_vector;
    logic [15:0] dummy_data;
    logic pe_valid = 1'b0;
    logic [FAP_N_SECT-1:0] pe_sectors = '0;
    logic pe_done;
    logic pe_blocked;
    logic [FAP_N_SECT-1:0] pe_permit;
    logic access_protected;
    logic debug_protected;
    logic [31:0] rd;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    always #2.5 ref_clk = ~ref_clk;

    fap_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .fetch_src(fetch_src), .nv_fuses(nv_fuses), .nv_prog(nv_prog), .acc_req(acc_req),
        .acc_verdict(acc_verdict), .trap_vector(trap_vector), .dummy_data(dummy_data),
        .pe_valid(pe_valid), .pe_sectors(pe_sectors), .pe_done(pe_done), .pe_blocked(pe_blocked),
        .pe_permit(pe_permit), .access_protected(access_protected), .debug_protected(debug_protected));
    fap_fuse_model i_fuse (.ref_clk(ref_clk), .nv_prog(nv_prog), .nv_fuses(nv_fuses));

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles >= 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // ****************************************
    // Access tasks
    // ****************************************
    task automatic wb(input fap_src_e src, input logic we, input logic [21:0] idx, input logic [15:0] d);
        @(posedge ref_clk);
        fetch_src <= src;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_dat_w <= {16'h0000, d};
        @(posedge ref_clk);
        while (wb_ack !== 1'b1) @(posedge ref_clk);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        // Let a fuse programming pulse reach the cells before anyone looks
        if (we) begin
            repeat (2) @(posedge ref_clk);
        end
    endtask
    task automatic st(input logic [31:0] mask, input logic [31:0] exp);
        wb(FAP_SRC_IRAM, 1'b0, FAP_IDX_STATUS, 16'h0000);
        check("status", rd & mask, exp);
    endtask
    task automatic acc(input fap_src_e src, input logic w, input logic p, input logic c, input logic [3:0] exp);
        @(posedge ref_clk);
        fetch_src <= src;
        acc_req <= '{1'b1, w, p, c};
        @(posedge ref_clk);
        acc_req <= '0;
        @(posedge ref_clk);
        check("verdict", acc_verdict, exp);
    endtask
    task automatic pe(input logic [FAP_N_SECT-1:0] s, input logic [FAP_N_SECT-1:0] exp);
        @(posedge ref_clk);
        pe_valid <= 1'b1;
        pe_sectors <= s;
        @(posedge ref_clk);
        pe_valid <= 1'b0;
        @(posedge ref_clk);
        check("pe_done", pe_done, 1'b1);
        check("pe_permit", pe_permit, exp);
        check("pe_blocked", pe_blocked, (s & ~exp) != '0);
    endtask
    task automatic do_reset(input int hold);
        int n;
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (hold) @(posedge ref_clk);
        check("prot_in_reset", {access_protected, debug_protected}, 2'b11);
        rstn <= 1'b1;
        n = 0;
        rd = '0;
        while (rd[FAP_ST_LOADED] !== 1'b1 && n < 20) begin
            wb(FAP_SRC_IRAM, 1'b0, FAP_IDX_STATUS, 16'h0000);
            n++;
        end
        check("loaded", rd[FAP_ST_LOADED], 1'b1);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        do_reset(10);
        st(32'h1f, 32'h01);
        wb(FAP_SRC_IRAM, 1'b0, FAP_IDX_TEMP_UNPROT, 16'h0000);
        check("unprot", rd[0], 1'b0);
        // First disable fuse refused before access and debug fuses
        wb(FAP_SRC_IRAM, 1'b1, FAP_IDX_DISABLE, 16'hfffe);
        check("disable_fuse", nv_fuses.disable_f, 16'hffff);
        st(32'h08, 32'h08);
        wb(FAP_SRC_IRAM, 1'b1, FAP_IDX_ACCESS_FUSES, 16'hfffc);
        check("access_fuse", nv_fuses.access, 16'hfffc);
        do_reset(3);
        st(32'h16, 32'h06);
        acc(FAP_SRC_IRAM, 1'b0, 1'b0, 1'b0, 4'b1011);
        check("trap_vector", trap_vector, 16'h009b);
        check("dummy", dummy_data, FAP_DUMMY_DATA);
        acc(FAP_SRC_XRAM, 1'b1, 1'b0, 1'b0, 4'b1000);
        acc(FAP_SRC_FLASH, 1'b0, 1'b0, 1'b0, 4'b1100);
        acc(FAP_SRC_EXT, 1'b0, 1'b0, 1'b0, 4'b1011);
        acc(FAP_SRC_IRAM, 1'b1, 1'b1, 1'b0, 4'b1000);
        acc(FAP_SRC_FLASH, 1'b1, 1'b0, 1'b1, 4'b1000);
        acc(FAP_SRC_EXT, 1'b0, 1'b0, 1'b1, 4'b1100);
        wb(FAP_SRC_IRAM, 1'b1, FAP_IDX_DISABLE, 16'hfffe);
        check("disable_fuse", nv_fuses.disable_f, 16'hffff);
        // Temporary unprotect only from flash code
        wb(FAP_SRC_IRAM, 1'b1, FAP_IDX_TEMP_UNPROT, 16'h0001);
        wb(FAP_SRC_IRAM, 1'b0, FAP_IDX_TEMP_UNPROT, 16'h0000);
        check("unprot", rd[0], 1'b0);
        wb(FAP_SRC_FLASH, 1'b1, FAP_IDX_TEMP_UNPROT, 16'h0001);
        wb(FAP_SRC_IRAM, 1'b0, FAP_IDX_TEMP_UNPROT, 16'h0000);
        check("unprot", rd[0], 1'b1);
        st(32'h02, 32'h00);
        acc(FAP_SRC_IRAM, 1'b0, 1'b0, 1'b0, 4'b1100);
        acc(FAP_SRC_IRAM, 1'b1, 1'b1, 1'b0, 4'b1100);
        wb(FAP_SRC_FLASH, 1'b1, FAP_IDX_TEMP_UNPROT, 16'h0000);
        st(32'h02, 32'h02);
        wb(FAP_SRC_FLASH, 1'b1, FAP_IDX_TEMP_UNPROT, 16'h0001);
        wb(FAP_SRC_IRAM, 1'b1, FAP_IDX_STATUS, 16'h0008);
        st(32'h08, 32'h00);
        // Bit 1 must be dropped while re-enable bit 0 is erased
        wb(FAP_SRC_IRAM, 1'b1, FAP_IDX_DISABLE, 16'hfffc);
        check("disable_fuse", nv_fuses.disable_f, 16'hfffe);
        st(32'h08, 32'h08);
        do_reset(3);
        st(32'h16, 32'h10);
        acc(FAP_SRC_IRAM, 1'b0, 1'b0, 1'b0, 4'b1100);
        wb(FAP_SRC_IRAM, 1'b1, FAP_IDX_REENABLE, 16'hfffc);
        check("reenable_fuse", nv_fuses.reenable, 16'hfffe);
        do_reset(3);
        st(32'h16, 32'h06);
        wb(FAP_SRC_FLASH, 1'b1, FAP_IDX_TEMP_UNPROT, 16'h0001);
        wb(FAP_SRC_IRAM, 1'b1, FAP_IDX_DISABLE, 16'hfffc);
        check("disable_fuse", nv_fuses.disable_f, 16'hfffc);
        do_reset(3);
        st(32'h16, 32'h10);
        // Sector write protection and its temporary override
        wb(FAP_SRC_FLASH, 1'b1, FAP_IDX_SECTOR_WP, 16'h03fe);
        check("sector_fuse", nv_fuses.sector[0], 1'b1);
        wb(FAP_SRC_IRAM, 1'b1, FAP_IDX_SECTOR_WP, 16'h03fe);
        check("sector_fuse", nv_fuses.sector[0], 1'b0);
        pe(10'h003, 10'h002);
        do_reset(3);
        pe(10'h003, 10'h002);
        wb(FAP_SRC_IRAM, 1'b1, FAP_IDX_SECTOR_WP, 16'h03ff);
        pe(10'h003, 10'h003);
        check("sector_fuse", nv_fuses.sector[0], 1'b0);
        wb(FAP_SRC_IRAM, 1'b0, FAP_IDX_SECTOR_WP, 16'h0000);
        check("sector_read", rd[1:0], 2'b10);
        wb(FAP_SRC_IRAM, 1'b1, FAP_IDX_SECTOR_WP, 16'h03fe);
        pe(10'h003, 10'h002);
        wrap_up();
    end
endmodule
